/* File: scp_dev_model.sv */
// Behavioural model of one chained register device
`timescale 1ns/1ps
module scp_dev_model #(
   parameter logic [5:0] CHAIN_ID = 6'h05,
   // Fall-to-fall span: one packet plus the longer minimum pair gap
   parameter real GAP_NS = 8480.0
) (
   // Serial pins
   input wire logic sck,
   input wire logic cmd,
   input wire logic din,
   // Read data toward the host, observed state
   output logic dq_oe,
   output logic dq,
   output int viol,
   output logic fast
);
   logic [15:0] regs [0:4095];
   logic [63:0] sh = 64'h0;
   logic [15:0] req = 16'h0;
   logic [11:0] adr = 12'h0;
   logic pcmd = 1'b0;
   logic prise = 1'b0;
   logic prise1 = 1'b0;
   logic pend = 1'b0;
   logic sel = 1'b0;
   int cnt = 0;
   realtime t_set = 0;
   initial begin
      dq_oe = 1'b0;
      dq = 1'b0;
      viol = 0;
      fast = 1'b0;
      foreach (regs[i]) regs[i] = 16'h0;
   end
   // Framing: cmd low at the rises of cycles 3 to 7; keep the last two rise samples
   always @(posedge sck) begin
      if (cnt >= 3 && cnt <= 7 && cmd) viol++;
      prise1 = prise;
      prise = cmd;
   end
   // Capture on the fall; a frame counts once cmd drops after its high half.
   // The clock stands still after a port reset, so a low cmd is never seen
   // before the next frame: only the high-to-low step can mark the frame.
   always @(negedge sck) begin
      sh = {sh[62:0], din};
      if (cnt != 0) begin
         cnt++;
      end else if (pcmd && !prise && !cmd) begin
         cnt = 3;
         if (!prise1) viol++;
      end
      pcmd = cmd;
      if (cnt == 16) begin
         req = sh[15:0];
         sel = req[5] || {req[10], req[4:0]} == CHAIN_ID;
         if (req[15:11] != 5'h0 || (pend && req[9:6] != 4'hb)) viol++;
         case (req[9:6])
            4'h0, 4'h1, 4'hf: ;
            4'h2: begin
               pend = 1'b1;
               t_set = $realtime;
               foreach (regs[i]) regs[i] = 16'h0;
            end
            4'hb: begin
               if (!pend || $realtime - t_set < GAP_NS) viol++;
               pend = 1'b0;
            end
            4'h4: fast = 1'b1;
            default: viol++;
         endcase
         if (req[9:7] != 3'h0) cnt = 0;
      end
      if (cnt == 32 && sh[15:12] != 4'h0) viol++;
      if (cnt == 32) adr = sh[11:0];
      if (cnt == 48 && !req[6] && sh[15:0] != 16'h0) viol++;
      if (cnt == 64 && req[6]) begin
         if (sh[15:0] != 16'h0) viol++;
         if (sel) regs[adr] = sh[31:16];
         cnt = 0;
      end
      if (cnt >= 49 && !req[6]) begin
         dq = (cnt < 65) ? regs[adr][64 - cnt] : ~dq;
         dq_oe = sel && cnt < 65;
         if (cnt == 65) cnt = 0;
      end
   end
endmodule

/* File: scp_host.sv */
// Host controller for a daisy-chained serial register port, programmed over AXI4-Lite
// ==========================================================
`timescale 1ns/1ps
`include "scp_map.svh"
module scp_host #(
   parameter int SCK_HALF = 4,
   parameter int CH_TCYCLE_PS = 1875,
   parameter int PORT_RST_SCYC = `SCP_PORT_RST_SCYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Serial chain pins
   output scp_pkg::scp_pin_out_t pin_out,
   input wire logic chain_data_up_in
);
   import scp_pkg::*;

   // ==========================================================
   // Derived timing
   localparam logic [7:0] PER_M1 = 8'(2 * SCK_HALF - 1);
   localparam logic [7:0] HALF = 8'(SCK_HALF);
   localparam logic [7:0] FALL_AT = 8'(SCK_HALF - 1);
   localparam logic [7:0] QTR1 = 8'(SCK_HALF / 2 - 1);
   localparam logic [7:0] QTR3 = 8'(SCK_HALF + SCK_HALF / 2 - 1);
   localparam int RST_SCK_CYC = `SCP_RST_GAP_SCYC * 2 * SCK_HALF;
   localparam int RST_CH_CYC =
      (`SCP_RST_GAP_TCYC * CH_TCYCLE_PS + `SCP_CLK_PS - 1) / `SCP_CLK_PS;
   localparam logic [15:0] GAP_RST =
      16'((RST_SCK_CYC > RST_CH_CYC) ? RST_SCK_CYC : RST_CH_CYC);
   localparam logic [15:0] GAP_POST = 16'(`SCP_POST_SCYC * 2 * SCK_HALF);
   localparam logic [6:0] BITS = 7'(`SCP_PKT_BITS);

   // Byte-lane merge of a register word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   // Request packet word, cycle 0 in bit 15; reserved bits are zero
   function automatic logic [15:0] req_word(input logic [3:0] sop, input logic bc,
                                            input logic [5:0] dev);
      return {5'h00, dev[5], sop, bc, dev[4:0]};
   endfunction

   // ==========================================================
   // State
   scp_state_t state;
   scp_ctrl_t ctrl;
   logic [7:0] cnt;
   logic [6:0] cyc;
   logic [6:0] total;
   logic [63:0] shreg;
   logic [15:0] wait_cnt;
   logic [3:0] cur_sop;
   logic rd_job;
   logic prst_job;
   logic pair_pending;
   logic [11:0] reg_address_bits;
   logic [15:0] reg_data_bits;
   logic [15:0] read_result;
   logic port_ready;
   logic refused;
   logic done;
   logic [2:0] sync;
   logic din;

   // ==========================================================
   // AXI4-Lite decode
   wire aw_hs = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   wire ar_hs = s_axi_arvalid && !s_axi_rvalid;
   wire wr_ctrl = aw_hs && s_axi_awaddr == `SCP_OFF_CTRL;
   wire wr_addr = aw_hs && s_axi_awaddr == `SCP_OFF_ADDR;
   wire wr_wdata = aw_hs && s_axi_awaddr == `SCP_OFF_WDATA;
   wire wr_stat = aw_hs && s_axi_awaddr == `SCP_OFF_STATUS;
   wire wr_ok = wr_ctrl || wr_addr || wr_wdata || wr_stat ||
                s_axi_awaddr == `SCP_OFF_RDATA;
   wire [31:0] ctrl_word = {18'h0, ctrl.dev, 3'h0, ctrl.bc, ctrl.op, 1'b0};
   wire [31:0] stat_word = {28'h0, done, refused, port_ready, state != SCP_ST_IDLE};
   wire [31:0] ctrl_new = merge(ctrl_word, s_axi_wdata, s_axi_wstrb);
   wire [31:0] addr_new = merge({20'h0, reg_address_bits}, s_axi_wdata, s_axi_wstrb);
   wire [31:0] data_new = merge({16'h0, reg_data_bits}, s_axi_wdata, s_axi_wstrb);
   wire [2:0] op_raw = ctrl_new[`SCP_CTRL_OP_LSB +: 3];
   wire [31:0] rd_word =
      (s_axi_araddr == `SCP_OFF_CTRL) ? ctrl_word :
      (s_axi_araddr == `SCP_OFF_ADDR) ? {20'h0, reg_address_bits} :
      (s_axi_araddr == `SCP_OFF_WDATA) ? {16'h0, reg_data_bits} :
      (s_axi_araddr == `SCP_OFF_RDATA) ? {16'h0, read_result} :
      (s_axi_araddr == `SCP_OFF_STATUS) ? stat_word : 32'h0000_0000;
   wire rd_ok = s_axi_araddr == `SCP_OFF_CTRL || s_axi_araddr == `SCP_OFF_ADDR ||
                s_axi_araddr == `SCP_OFF_WDATA || s_axi_araddr == `SCP_OFF_RDATA ||
                s_axi_araddr == `SCP_OFF_STATUS;
   assign s_axi_awready = aw_hs;
   assign s_axi_wready = aw_hs;
   assign s_axi_arready = !s_axi_rvalid;

   // ==========================================================
   // Command acceptance: no access before the port reset, one job at a time
   wire go_req = wr_ctrl && s_axi_wstrb[0] && s_axi_wdata[`SCP_CTRL_GO];
   wire op_legal = op_raw <= 3'b101;
   wire go_ok = go_req && state == SCP_ST_IDLE && op_legal &&
                (port_ready || op_raw == SCP_H_PRST);
   wire go_bad = go_req && !go_ok;
   wire last_cyc = cyc == total - 7'h01;
   wire at_end = cnt == PER_M1;
   wire run_end = state == SCP_ST_SHIFT && at_end && last_cyc;
   wire pair_go = state == SCP_ST_GAP && wait_cnt == 16'h0000 && pair_pending;
   wire launch = go_ok || pair_go;
   wire job_done = state == SCP_ST_GAP && wait_cnt == 16'h0000 && !pair_pending;

   // ==========================================================
   // Job loading: opcode, packet image and length
   wire [2:0] l_op = pair_go ? SCP_H_RSTPAIR : op_raw;
   wire [6:0] l_dev_bc = pair_go ? {ctrl.dev, ctrl.bc} :
                         {ctrl_new[`SCP_CTRL_DEV_LSB +: 6], ctrl_new[`SCP_CTRL_BC]};
   wire [3:0] l_sop = pair_go ? `SCP_SOP_RESET_RELEASE :
                      (l_op == SCP_H_READ) ? `SCP_SOP_READ :
                      (l_op == SCP_H_WRITE) ? `SCP_SOP_WRITE :
                      (l_op == SCP_H_RSTPAIR) ? `SCP_SOP_RESET_ASSERT :
                      (l_op == SCP_H_FAST) ? `SCP_SOP_FAST_CLOCK : `SCP_SOP_NOP;
   wire l_prst = !pair_go && l_op == SCP_H_PRST;
   wire l_rd = !pair_go && l_op == SCP_H_READ;
   wire l_wr = !pair_go && l_op == SCP_H_WRITE;
   // Write: request, address, data, interval; read: request, address, interval
   wire [63:0] l_shreg = l_prst ? 64'h0 :
      {req_word(l_sop, l_dev_bc[0], l_dev_bc[6:1]), 4'h0, reg_address_bits,
       l_wr ? reg_data_bits : 16'h0000, 16'h0000};
   // Read keeps one extra cycle to catch the last half-period-late bit
   wire [6:0] l_total = l_prst ? 7'(PORT_RST_SCYC) :
                        l_rd ? 7'(4 * `SCP_PKT_BITS + 1) :
                        l_wr ? 7'(4 * `SCP_PKT_BITS) : BITS;
   wire [15:0] post_wait = (cur_sop == `SCP_SOP_RESET_ASSERT) ? GAP_RST :
                           (cur_sop == `SCP_SOP_RESET_RELEASE ||
                            cur_sop == `SCP_SOP_FAST_CLOCK) ? GAP_POST : 16'h0000;

   // ==========================================================
   // Serial clock phases: rise, fall, command update and read sample points
   wire [6:0] next_cyc = (state == SCP_ST_LEAD) ? 7'h00 : cyc + 7'h01;
   wire rise_act = at_end && (state == SCP_ST_LEAD || (state == SCP_ST_SHIFT && !last_cyc));
   wire fall_act = state == SCP_ST_SHIFT && cnt == FALL_AT;
   wire cmd_act = (state == SCP_ST_LEAD || state == SCP_ST_SHIFT) && cnt == QTR3;
   wire cmd_val = prst_job ? (state == SCP_ST_LEAD || !last_cyc) :
                  (state == SCP_ST_LEAD || cyc == 7'h00);
   wire sample_act = state == SCP_ST_SHIFT && cnt == QTR1 && rd_job &&
                     cyc >= 7'(3 * `SCP_PKT_BITS + 1);
   wire next_oe = !(rd_job && next_cyc >= 7'(3 * `SCP_PKT_BITS));

   // AXI response channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'b00;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         if (aw_hs) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
            s_axi_rdata <= rd_word;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Software-visible registers; refused and done are write-one-to-clear, set wins; port_ready clears only on reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= scp_ctrl_t'(10'h000);
         reg_address_bits <= 12'h000;
         reg_data_bits <= 16'h0000;
         refused <= 1'b0;
         done <= 1'b0;
         port_ready <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= {ctrl_new[`SCP_CTRL_DEV_LSB +: 6], ctrl_new[`SCP_CTRL_BC],
                     scp_hcmd_t'(op_raw)};
         end
         if (wr_addr) begin
            reg_address_bits <= addr_new[11:0];
         end
         if (wr_wdata) begin
            reg_data_bits <= data_new[15:0];
         end
         refused <= go_bad || (refused && !(wr_stat && s_axi_wdata[`SCP_STAT_REFUSED]));
         done <= job_done || (done && !(wr_stat && s_axi_wdata[`SCP_STAT_DONE]));
         port_ready <= port_ready || (run_end && prst_job);
      end
   end

   // Sequencer: lead half period, shifting cycles, then a post-command wait
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= SCP_ST_IDLE;
         cnt <= 8'h00;
         cyc <= 7'h00;
         wait_cnt <= 16'h0000;
      end else begin
         unique case (state)
            SCP_ST_IDLE: begin
               if (launch) begin
                  state <= SCP_ST_LEAD;
                  cnt <= HALF;
               end
            end
            SCP_ST_LEAD: begin
               cnt <= at_end ? 8'h00 : cnt + 8'h01;
               if (at_end) begin
                  state <= SCP_ST_SHIFT;
                  cyc <= 7'h00;
               end
            end
            SCP_ST_SHIFT: begin
               cnt <= at_end ? 8'h00 : cnt + 8'h01;
               if (run_end) begin
                  state <= SCP_ST_GAP;
                  wait_cnt <= post_wait;
               end else if (at_end) begin
                  cyc <= cyc + 7'h01;
               end
            end
            SCP_ST_GAP: begin
               if (wait_cnt != 16'h0000) begin
                  wait_cnt <= wait_cnt - 16'h0001;
               end else if (pair_go) begin
                  state <= SCP_ST_LEAD;
                  cnt <= HALF;
               end else begin
                  state <= SCP_ST_IDLE;
               end
            end
         endcase
      end
   end

   // Job image and shift register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shreg <= 64'h0;
         total <= 7'h01;
         rd_job <= 1'b0;
         prst_job <= 1'b0;
         pair_pending <= 1'b0;
         cur_sop <= `SCP_SOP_NOP;
      end else if (launch) begin
         shreg <= l_shreg;
         total <= l_total;
         rd_job <= l_rd;
         prst_job <= l_prst;
         pair_pending <= !pair_go && l_op == SCP_H_RSTPAIR;
         cur_sop <= l_sop;
      end else if (rise_act) begin
         shreg <= {shreg[62:0], 1'b0};
      end
   end

   // Pins: data changes with the rising edge so the device's falling-edge capture is clean
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= 4'b0001;
      end else begin
         if (rise_act) begin
            pin_out.sck <= 1'b1;
            pin_out.data <= shreg[63];
            pin_out.data_oe <= next_oe;
         end else if (fall_act) begin
            pin_out.sck <= 1'b0;
         end else if (state == SCP_ST_GAP || state == SCP_ST_IDLE) begin
            pin_out.data <= 1'b0;
            pin_out.data_oe <= 1'b1;
         end
         if (cmd_act) begin
            pin_out.cmd <= cmd_val;
         end
      end
   end

   // Read data input: three flops, a change counts once the last two agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync <= 3'b000;
         din <= 1'b0;
         read_result <= 16'h0000;
      end else begin
         sync <= {sync[1:0], chain_data_up_in};
         if (sync[1] == sync[2]) begin
            din <= sync[2];
         end
         if (sample_act) begin
            read_result <= {read_result[14:0], din};
         end
      end
   end

   // ==========================================================
   // Checking helpers: time since a run ended and the opcode of that run
   logic [15:0] since_end;
   logic [3:0] last_sop;
   scp_state_t prev_state;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         since_end <= 16'hffff;
         last_sop <= `SCP_SOP_NOP;
         prev_state <= SCP_ST_IDLE;
      end else begin
         prev_state <= state;
         if (run_end) begin
            since_end <= 16'h0000;
            last_sop <= cur_sop;
         end else if (since_end != 16'hffff) begin
            since_end <= since_end + 16'h0001;
         end
      end
   end
   wire lead_start = state == SCP_ST_LEAD && prev_state != SCP_ST_LEAD;

   chk_sck_before_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      !port_ready && !prst_job |-> !pin_out.sck)
      else $error("serial clock toggled before the port reset");
   chk_frame_high: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pin_out.sck) && !prst_job && cyc <= 7'h01 |-> pin_out.cmd)
      else $error("command line low in the first two frame cycles");
   chk_frame_low: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pin_out.sck) && !prst_job && cyc >= 7'h02 |-> !pin_out.cmd)
      else $error("command line high after the frame");
   chk_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pin_out.sck) && !prst_job && (cyc < 7'h05 ||
      (cyc >= BITS && cyc < BITS + 7'h04)) |-> !pin_out.data)
      else $error("reserved packet bit driven high");
   chk_packet_count: assert property (@(posedge aclk) disable iff (!aresetn)
      run_end && !prst_job |-> (rd_job ? total == 7'h41 :
      (cur_sop == `SCP_SOP_WRITE ? total == 7'h40 : total == BITS)))
      else $error("transaction length is not whole packets");
   chk_pair_order: assert property (@(posedge aclk) disable iff (!aresetn)
      lead_start && cur_sop == `SCP_SOP_RESET_RELEASE |->
      last_sop == `SCP_SOP_RESET_ASSERT)
      else $error("reset release not preceded by reset assert");
   chk_pair_gap: assert property (@(posedge aclk) disable iff (!aresetn)
      lead_start && cur_sop == `SCP_SOP_RESET_RELEASE |-> since_end >= GAP_RST)
      else $error("reset pair gap too short");
   chk_post_wait: assert property (@(posedge aclk) disable iff (!aresetn)
      lead_start && (last_sop == `SCP_SOP_RESET_RELEASE ||
      last_sop == `SCP_SOP_FAST_CLOCK) |-> since_end >= GAP_POST)
      else $error("command issued too soon after reset release or fast clock");
   chk_read_release: assert property (@(posedge aclk) disable iff (!aresetn)
      state == SCP_ST_SHIFT && rd_job && cyc >= 7'h30 |-> !pin_out.data_oe)
      else $error("host drives the data pin during read data");
   chk_drive_request: assert property (@(posedge aclk) disable iff (!aresetn)
      state == SCP_ST_SHIFT && cyc < 7'h30 |-> pin_out.data_oe)
      else $error("host not driving the data pin while sending");
endmodule

/* File: scp_map.svh */
// Offsets, field positions, opcodes and timing figures of the serial register port host
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH
// ==========================================================
// Host register offsets (byte addresses on AXI4-Lite)
`define SCP_OFF_CTRL 8'h00
`define SCP_OFF_ADDR 8'h04
`define SCP_OFF_WDATA 8'h08
`define SCP_OFF_RDATA 8'h0c
`define SCP_OFF_STATUS 8'h10
// ==========================================================
// Field positions
`define SCP_CTRL_GO 0
`define SCP_CTRL_OP_LSB 1
`define SCP_CTRL_BC 4
`define SCP_CTRL_DEV_LSB 8
`define SCP_STAT_BUSY 0
`define SCP_STAT_READY 1
`define SCP_STAT_REFUSED 2
`define SCP_STAT_DONE 3
// ==========================================================
// Serial opcodes carried in the request packet
`define SCP_SOP_READ 4'h0
`define SCP_SOP_WRITE 4'h1
`define SCP_SOP_RESET_ASSERT 4'h2
`define SCP_SOP_FAST_CLOCK 4'h4
`define SCP_SOP_RESET_RELEASE 4'hb
`define SCP_SOP_NOP 4'hf
// ==========================================================
// Timing and lengths
`define SCP_CLK_PS 25000
`define SCP_PKT_BITS 16
`define SCP_RST_GAP_SCYC 16
`define SCP_RST_GAP_TCYC 2816
`define SCP_POST_SCYC 4
`define SCP_PORT_RST_SCYC 32
`define SCP_RESET_CTRL 32'h0000_0000
`endif

/* File: scp_pkg.sv */
// Types shared by the serial register port host
package scp_pkg;
   // Host command codes written into the control register
   typedef enum logic [2:0] {
      SCP_H_PRST = 3'b000,
      SCP_H_READ = 3'b001,
      SCP_H_WRITE = 3'b010,
      SCP_H_NOP = 3'b011,
      SCP_H_RSTPAIR = 3'b100,
      SCP_H_FAST = 3'b101
   } scp_hcmd_t;
   // Sequencer states
   typedef enum logic [1:0] {
      SCP_ST_IDLE = 2'b00,
      SCP_ST_LEAD = 2'b01,
      SCP_ST_SHIFT = 2'b10,
      SCP_ST_GAP = 2'b11
   } scp_state_t;
   // Control register contents
   typedef struct packed {
      logic [5:0] dev;
      logic bc;
      scp_hcmd_t op;
   } scp_ctrl_t;
   // Pins driven toward the device chain
   typedef struct packed {
      logic sck;
      logic cmd;
      logic data;
      logic data_oe;
   } scp_pin_out_t;
endpackage

/* File: testbench.sv */
// Self-checking bench for the serial register port host
`timescale 1ns/1ps
`include "scp_map.svh"
module testbench;
   import scp_pkg::*;
   localparam logic [5:0] ID = 6'h05;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   scp_pin_out_t pin_out;
   logic dq, dq_oe, fast;
   int viol;
   // Line undriven by both ends shows the inverse, so a stray sample shows up
   wire logic chain_data_up_in = pin_out.data_oe ? pin_out.data : (dq_oe ? dq : ~dq);
   int failures = 0, compares = 0, n = 0, n2 = 0;
   logic [65:0] q[$];
   logic [65:0] note;
   logic [31:0] seed = 32'h459c, got, d;
   scp_host #(.PORT_RST_SCYC(16)) dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .pin_out, .chain_data_up_in
   );
   scp_dev_model #(.CHAIN_ID(ID)) partner (
      .sck(pin_out.sck), .cmd(pin_out.cmd), .din(chain_data_up_in), .dq_oe, .dq, .viol, .fast
   );
   initial forever #12.5 aclk = ~aclk;
   // ==========================================================
   // Shared tasks
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Bounded wait for a handshake sampled at the rising edge
   task automatic await(ref logic s);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (s !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         chk("handshake", 32'h0, 32'h1);
         conclude();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      q.push_back({r, 64'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      await(s_axi_awready);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      await(s_axi_bvalid);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] r, output logic [31:0] v);
      q.push_back({r, m, e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      await(s_axi_arready);
      s_axi_arvalid <= 1'b0;
      await(s_axi_rvalid);
      v = s_axi_rdata;
   endtask
   // Start a serial operation, poll until done, then clear done
   task automatic run(input scp_hcmd_t op, input logic bc, input logic [5:0] dev);
      wr(`SCP_OFF_CTRL, {18'h0, dev, 3'h0, bc, op, 1'b1}, 2'b00);
      n2 = 0;
      do begin
         rd(`SCP_OFF_STATUS, 32'h0, 32'h0, 2'b00, got);
         n2++;
      end while (got[`SCP_STAT_DONE] !== 1'b1 && n2 < 400);
      chk("status", got, 32'ha);
      if (got[`SCP_STAT_DONE] !== 1'b1) begin
         conclude();
      end
      wr(`SCP_OFF_STATUS, 32'h8, 2'b00);
   endtask
   // Oldest note against each response as it appears
   always @(posedge aclk) begin
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
         note = q.pop_front();
         chk("resp", {30'h0, s_axi_bvalid ? s_axi_bresp : s_axi_rresp}, {30'h0, note[65:64]});
         if (s_axi_rvalid) chk("rdata", s_axi_rdata & note[63:32], note[31:0]);
      end
   end
   initial begin
      repeat (100000) @(posedge aclk);
      chk("watchdog", 32'h0, 32'h1);
      conclude();
   end
   // ==========================================================
   // Scenarios
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`SCP_OFF_STATUS, 32'hffffffff, 32'h0, 2'b00, got);
      wr(`SCP_OFF_CTRL, 32'h3, 2'b00);
      rd(`SCP_OFF_STATUS, 32'hf, 32'h4, 2'b00, got);
      wr(`SCP_OFF_STATUS, 32'h4, 2'b00);
      run(SCP_H_PRST, 1'b0, ID);
      $display("test port reset done");
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         d = {16'h0, seed[15:0]};
         wr(`SCP_OFF_ADDR, {20'h0, seed[11:0]}, 2'b00);
         wr(`SCP_OFF_WDATA, d, 2'b00);
         run(SCP_H_WRITE, i == 1, (i == 1) ? ~ID : ID);
         if (i == 2) begin
            wr(`SCP_OFF_WDATA, ~d, 2'b00);
            run(SCP_H_WRITE, 1'b0, ID ^ 6'h01);
         end
         run(SCP_H_READ, 1'b0, ID);
         rd(`SCP_OFF_RDATA, 32'hffff, d, 2'b00, got);
      end
      $display("test write and read done");
      run(SCP_H_RSTPAIR, 1'b1, ID);
      run(SCP_H_READ, 1'b0, ID);
      rd(`SCP_OFF_RDATA, 32'hffff, 32'h0, 2'b00, got);
      // Byte lane merge: only the low byte of the address register changes
      s_axi_wstrb <= 4'h1;
      wr(`SCP_OFF_ADDR, 32'hffff_ffff, 2'b00);
      s_axi_wstrb <= 4'hf;
      rd(`SCP_OFF_ADDR, 32'hffff_ffff, {20'h0, seed[11:8], 8'hff}, 2'b00, got);
      run(SCP_H_FAST, 1'b1, ID);
      chk("fast", {31'h0, fast}, 32'h1);
      run(SCP_H_NOP, 1'b0, ID);
      $display("test single packet ops done");
      wr(`SCP_OFF_CTRL, 32'hd, 2'b00);
      rd(`SCP_OFF_STATUS, 32'h5, 32'h4, 2'b00, got);
      wr(8'h20, 32'h1, 2'b10);
      rd(8'h20, 32'hffffffff, 32'h0, 2'b10, got);
      chk("violations", viol, 32'h0);
      $display("test refusals done");
      repeat (2) @(posedge aclk);
      conclude();
   end
endmodule
